// >>> hdl/efs_supervisor.sv
// encoder feedback supervisor: speed, direction, faults, divided pulse output
//
// Overview of operation
// - overspeed when speed above level for time
// - overspeed reaction: decel, coast or continue
// - deviation fault when error persists for time
// - deviation band centred on reference speed
// - deviation reaction: decel, coast or continue
// - encoder loss when no pulses for time
// - encoder loss reaction: decel, coast, continue
// - pulses per revolution counted on phase A
// - selector 0: A leading means forward
// - selector 1: B leading means forward
// - divider n is 1 at settings of 100 and above, k is the low 7 bits of setting minus 100n, or 1 at setting 0
// - output pulse rate is input times (1+n)/k
// - two gear tooth counts scale encoder speed
// - rpm = pps*60/ppr * load/encoder teeth
//
// Design decisions made here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module efs_supervisor
    import efs_pkg::*;
#(
    parameter int GATE_CYCLES = efs_pkg::TICK_CYCLES
)
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [5:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [5:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic shaft_encoder_a,
    input wire logic shaft_encoder_b,
    input wire logic [15:0] ref_speed_rpm,
    output logic [15:0] speed_rpm,
    output logic dir_fwd,
    output logic enc_div_pulse,
    output logic overspeed_fault,
    output logic speed_deviation_fault,
    output logic encoder_loss_fault,
    output logic stop_decel,
    output logic stop_coast,
    output logic irq
);
    import efs_pkg::*;

    typedef enum logic {DIV_IDLE, DIV_RUN} efs_div_e;

    typedef struct packed {
        logic aw_got;
        logic w_got;
        logic [5:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [6:0] ctrl;
        logic [15:0] os_cfg;
        logic [15:0] dev_cfg;
        logic [7:0] loss_time;
        logic [15:0] ppr;
        logic [7:0] divset;
        logic [9:0] gear_enc;
        logic [9:0] gear_load;
        logic [15:0] max_rpm;
        logic [2:0] status;
        logic [2:0] mask;
        logic a_s1;
        logic a_s2;
        logic a_s3;
        logic a_f;
        logic b_s1;
        logic b_s2;
        logic b_s3;
        logic b_f;
        logic dir_fwd;
        logic [22:0] gate_cnt;
        logic [23:0] pulse_cnt;
        logic tick;
        efs_div_e div_state;
        logic [5:0] div_idx;
        logic [47:0] num;
        logic [25:0] den;
        logic [25:0] rem;
        logic [15:0] speed;
        logic [6:0] acc;
        logic div_pulse;
    } efs_state_s;

    efs_state_s r;
    efs_state_s next_r;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return res;
    endfunction : wmerge

    // value exceeds level percent of full-scale speed
    function automatic logic pct_over(input logic [15:0] val, input logic [6:0] level, input logic [15:0] full);
        logic [23:0] lhs;
        logic [23:0] rhs;
        lhs = 24'(val) * 24'(PCT_FULL);
        rhs = 24'(level) * 24'(full);
        return lhs > rhs;
    endfunction : pct_over

    function automatic logic [1:0] sel_of(input logic [6:0] ctrl, input int pos);
        return ctrl[pos +: 2];
    endfunction : sel_of

    function automatic logic is_mapped(input logic [5:0] a);
        return (a[1:0] == 2'h0) && (a <= OFS_MASK);
    endfunction : is_mapped

    // ------------------------------------------------------------
    // combinational terms
    // ------------------------------------------------------------
    logic a_new;
    logic b_new;
    logic a_rise;
    logic any_edge;
    logic os_cond;
    logic dev_cond;
    logic loss_cond;
    logic os_hit;
    logic dev_hit;
    logic loss_hit;
    logic [15:0] speed_err;
    logic div_n;
    logic [6:0] div_k;
    logic [2:0] faults;
    logic [2:0] decel_sel;
    logic [2:0] coast_sel;

    // a change counts only once the second and third stages agree
    assign a_new = (r.a_s2 == r.a_s3) ? r.a_s3 : r.a_f;
    assign b_new = (r.b_s2 == r.b_s3) ? r.b_s3 : r.b_f;
    assign a_rise = a_new & ~r.a_f;
    assign any_edge = (a_new ^ r.a_f) | (b_new ^ r.b_f);

    assign speed_err = (ref_speed_rpm > r.speed) ? ref_speed_rpm - r.speed : r.speed - ref_speed_rpm;
    assign os_cond = pct_over(r.speed, r.os_cfg[6:0], r.max_rpm);
    assign dev_cond = pct_over(speed_err, {1'b0, r.dev_cfg[5:0]}, r.max_rpm);
    assign loss_cond = ~any_edge;

    // divider setting: n is 1 from 100 up, k is the setting less 100 when n is 1
    assign div_n = (r.divset >= DIVSET_HUNDRED);
    assign div_k = (r.divset[6:0] == 7'h00 && !div_n) ? 7'h01
                 : (div_n ? 7'(r.divset - DIVSET_HUNDRED) : r.divset[6:0]);

    assign faults = {loss_hit, dev_hit, os_hit};

    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            decel_sel[i] = (sel_of(r.ctrl, 2 * i) == ACT_DECEL);
            coast_sel[i] = (sel_of(r.ctrl, 2 * i) == ACT_COAST);
        end
    end

    // ------------------------------------------------------------
    // fault persistence timers
    // ------------------------------------------------------------
    efs_persist #(.CNT_W(8)) u_os_timer (
        .clk_sys(clk_sys),
        .rst(rst),
        .cond(os_cond),
        .tick(r.tick),
        .limit(r.os_cfg[CFG_TIME +: 8]),
        .fault(os_hit)
    );

    efs_persist #(.CNT_W(8)) u_dev_timer (
        .clk_sys(clk_sys),
        .rst(rst),
        .cond(dev_cond),
        .tick(r.tick),
        .limit(r.dev_cfg[CFG_TIME +: 8]),
        .fault(dev_hit)
    );

    efs_persist #(.CNT_W(8)) u_loss_timer (
        .clk_sys(clk_sys),
        .rst(rst),
        .cond(loss_cond),
        .tick(r.tick),
        .limit(r.loss_time),
        .fault(loss_hit)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic [2:0] clr;
        logic [31:0] rd;
        logic [26:0] rem_sh;
        logic qbit;
        logic [7:0] acc_sum;
        clr = 3'h0;
        rd = 32'h0;
        rem_sh = 27'h0;
        qbit = 1'b0;
        acc_sum = 8'h0;
        next_r = r;

        // pin synchronisers
        next_r.a_s1 = shaft_encoder_a;
        next_r.a_s2 = r.a_s1;
        next_r.a_s3 = r.a_s2;
        next_r.b_s1 = shaft_encoder_b;
        next_r.b_s2 = r.b_s1;
        next_r.b_s3 = r.b_s2;
        next_r.a_f = a_new;
        next_r.b_f = b_new;

        // B still low as A rises means A leads
        if (a_rise)
        begin
            next_r.dir_fwd = ~b_new ^ r.ctrl[CTRL_DIR_SEL];
        end

        // measurement gate: pulses on phase A per tick
        next_r.tick = 1'b0;
        if (r.gate_cnt == 23'(GATE_CYCLES - 1))
        begin
            next_r.gate_cnt = 23'h0;
            next_r.tick = 1'b1;
            next_r.pulse_cnt = {23'h0, a_rise};
            // numerator and denominator of the rpm formula
            next_r.num = 48'(r.pulse_cnt) * 48'(RPM_SCALE) * 48'(r.gear_load);
            next_r.den = 26'(r.ppr) * 26'(r.gear_enc);
            next_r.rem = 26'h0;
            next_r.div_idx = 6'h0;
            if (next_r.den == 26'h0)
            begin
                next_r.speed = 16'h0;
            end
            else
            begin
                next_r.div_state = DIV_RUN;
            end
        end
        else
        begin
            next_r.gate_cnt = r.gate_cnt + 23'h1;
            next_r.pulse_cnt = r.pulse_cnt + {23'h0, a_rise};
        end

        // restoring divider, one quotient bit a cycle, quotient replaces num
        case (r.div_state)
            DIV_IDLE:
            begin
            end
            DIV_RUN:
            begin
                rem_sh = {r.rem, r.num[47]};
                qbit = (rem_sh >= {1'b0, r.den});
                next_r.rem = qbit ? 26'(rem_sh - {1'b0, r.den}) : rem_sh[25:0];
                next_r.num = {r.num[46:0], qbit};
                next_r.div_idx = r.div_idx + 6'h1;
                if (r.div_idx == 6'(DIV_STEPS - 1))
                begin
                    next_r.div_state = DIV_IDLE;
                    // saturate rather than wrap on absurd settings
                    next_r.speed = (next_r.num[47:16] != 32'h0) ? 16'hffff : next_r.num[15:0];
                end
            end
            default:
            begin
                next_r.div_state = DIV_IDLE;
            end
        endcase

        // output divider: add (1+n) per input pulse, emit one per k; a gap cycle keeps pulses apart
        acc_sum = {1'b0, r.acc} + {6'h0, a_rise & div_n, a_rise & ~div_n};
        if (acc_sum >= {1'b0, div_k} && !r.div_pulse)
        begin
            next_r.acc = 7'(acc_sum - {1'b0, div_k});
            next_r.div_pulse = 1'b1;
        end
        else
        begin
            next_r.acc = acc_sum[6:0];
            next_r.div_pulse = 1'b0;
        end

        // axi write channel
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_r.aw_got = 1'b1;
            next_r.waddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_r.w_got = 1'b1;
            next_r.wdata = s_axi_wdata;
            next_r.wstrb = s_axi_wstrb;
        end
        if (r.aw_got && r.w_got)
        begin
            next_r.aw_got = 1'b0;
            next_r.w_got = 1'b0;
            next_r.bvalid = 1'b1;
            next_r.bresp = is_mapped(r.waddr) ? AXI_OKAY : AXI_SLVERR;
            case (r.waddr)
                OFS_CTRL: next_r.ctrl = 7'(wmerge(32'(r.ctrl), r.wdata, r.wstrb));
                OFS_OS_CFG: next_r.os_cfg = 16'(wmerge(32'(r.os_cfg), r.wdata, r.wstrb));
                OFS_DEV_CFG: next_r.dev_cfg = 16'(wmerge(32'(r.dev_cfg), r.wdata, r.wstrb));
                OFS_LOSS_CFG: next_r.loss_time = 8'(wmerge(32'(r.loss_time), r.wdata, r.wstrb));
                OFS_PPR: next_r.ppr = 16'(wmerge(32'(r.ppr), r.wdata, r.wstrb));
                OFS_DIVSET: {next_r.divset, next_r.acc} = {8'(wmerge(32'(r.divset), r.wdata, r.wstrb)), 7'h0};
                OFS_GEAR:
                begin
                    rd = wmerge({6'h0, r.gear_load, 6'h0, r.gear_enc}, r.wdata, r.wstrb);
                    next_r.gear_enc = rd[9:0];
                    next_r.gear_load = rd[GEAR_LOAD +: 10];
                end
                OFS_MAX_RPM: next_r.max_rpm = 16'(wmerge(32'(r.max_rpm), r.wdata, r.wstrb));
                OFS_STATUS: clr = r.wstrb[0] ? r.wdata[2:0] : 3'h0;
                OFS_MASK: next_r.mask = 3'(wmerge(32'(r.mask), r.wdata, r.wstrb));
                default:
                begin
                end
            endcase
        end
        if (r.bvalid && s_axi_bready)
        begin
            next_r.bvalid = 1'b0;
        end

        // sticky events: a new fault wins over a clear in the same cycle
        next_r.status = (r.status & ~clr) | faults;

        // axi read channel
        if (s_axi_arvalid && s_axi_arready)
        begin
            case (s_axi_araddr)
                OFS_CTRL: rd = 32'(r.ctrl);
                OFS_OS_CFG: rd = 32'(r.os_cfg);
                OFS_DEV_CFG: rd = 32'(r.dev_cfg);
                OFS_LOSS_CFG: rd = 32'(r.loss_time);
                OFS_PPR: rd = 32'(r.ppr);
                OFS_DIVSET: rd = 32'(r.divset);
                OFS_GEAR: rd = {6'h0, r.gear_load, 6'h0, r.gear_enc};
                OFS_MAX_RPM: rd = 32'(r.max_rpm);
                OFS_SPEED: rd = {15'h0, r.dir_fwd, r.speed};
                OFS_STATUS: rd = 32'(r.status);
                OFS_MASK: rd = 32'(r.mask);
                default: rd = 32'h0;
            endcase
            next_r.rvalid = 1'b1;
            next_r.rdata = rd;
            next_r.rresp = is_mapped(s_axi_araddr) ? AXI_OKAY : AXI_SLVERR;
        end
        else if (r.rvalid && s_axi_rready)
        begin
            next_r.rvalid = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            r <= '0;
            r.ctrl <= RST_CTRL;
            r.os_cfg <= {RST_OS_TIME, 1'b0, RST_OS_LEVEL};
            r.dev_cfg <= {RST_DEV_TIME, 2'h0, RST_DEV_LEVEL};
            r.loss_time <= RST_LOSS_TIME;
            r.ppr <= RST_PPR;
            r.divset <= RST_DIVSET;
            r.gear_enc <= RST_GEAR;
            r.gear_load <= RST_GEAR;
            r.max_rpm <= RST_MAX_RPM;
            r.div_state <= DIV_IDLE;
        end
        else
        begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign s_axi_awready = ~r.aw_got & ~r.bvalid;
    assign s_axi_wready = ~r.w_got & ~r.bvalid;
    assign s_axi_bvalid = r.bvalid;
    assign s_axi_bresp = r.bresp;
    assign s_axi_arready = ~r.rvalid;
    assign s_axi_rvalid = r.rvalid;
    assign s_axi_rdata = r.rdata;
    assign s_axi_rresp = r.rresp;

    assign speed_rpm = r.speed;
    assign dir_fwd = r.dir_fwd;
    assign enc_div_pulse = r.div_pulse;
    assign overspeed_fault = r.status[ST_OS];
    assign speed_deviation_fault = r.status[ST_DEV];
    assign encoder_loss_fault = r.status[ST_LOSS];

    // reaction holds until software clears the fault; coast overrides decel
    assign stop_coast = |(r.status & coast_sel);
    assign stop_decel = |(r.status & decel_sel) & ~stop_coast;
    assign irq = |(r.status & r.mask);

endmodule : efs_supervisor

// >>> hdl/efs_pkg.sv
// constants shared by the encoder feedback supervisor
package efs_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 50_000_000;
    localparam int TICK_MS = 100;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int SEC_PER_MIN = 60;
    localparam int TICKS_PER_SEC = 1000 / TICK_MS;
    localparam int RPM_SCALE = SEC_PER_MIN * TICKS_PER_SEC;
    localparam int PCT_FULL = 100;
    localparam int DIV_STEPS = 48;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [5:0] OFS_CTRL = 6'h00;
    localparam logic [5:0] OFS_OS_CFG = 6'h04;
    localparam logic [5:0] OFS_DEV_CFG = 6'h08;
    localparam logic [5:0] OFS_LOSS_CFG = 6'h0c;
    localparam logic [5:0] OFS_PPR = 6'h10;
    localparam logic [5:0] OFS_DIVSET = 6'h14;
    localparam logic [5:0] OFS_GEAR = 6'h18;
    localparam logic [5:0] OFS_MAX_RPM = 6'h1c;
    localparam logic [5:0] OFS_SPEED = 6'h20;
    localparam logic [5:0] OFS_STATUS = 6'h24;
    localparam logic [5:0] OFS_MASK = 6'h28;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTRL_OS_SEL = 0;
    localparam int CTRL_DEV_SEL = 2;
    localparam int CTRL_LOSS_SEL = 4;
    localparam int CTRL_DIR_SEL = 6;
    localparam int CFG_TIME = 8;
    localparam int GEAR_LOAD = 16;
    localparam int SPEED_DIR = 16;
    localparam int ST_OS = 0;
    localparam int ST_DEV = 1;
    localparam int ST_LOSS = 2;

    // ------------------------------------------------------------
    // reaction codes and divider setting decode
    // ------------------------------------------------------------
    localparam logic [1:0] ACT_DECEL = 2'h0;
    localparam logic [1:0] ACT_COAST = 2'h1;
    localparam logic [1:0] ACT_RUN = 2'h2;
    localparam logic [7:0] DIVSET_HUNDRED = 8'h64;
    localparam logic [6:0] DIVK_MAX = 7'h20;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [6:0] RST_CTRL = 7'h00;
    localparam logic [6:0] RST_OS_LEVEL = 7'h78;
    localparam logic [7:0] RST_OS_TIME = 8'h0a;
    localparam logic [5:0] RST_DEV_LEVEL = 6'h0a;
    localparam logic [7:0] RST_DEV_TIME = 8'h05;
    localparam logic [7:0] RST_LOSS_TIME = 8'h0a;
    localparam logic [15:0] RST_PPR = 16'h0400;
    localparam logic [7:0] RST_DIVSET = 8'h01;
    localparam logic [9:0] RST_GEAR = 10'h001;
    localparam logic [15:0] RST_MAX_RPM = 16'h0708;

    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

endpackage : efs_pkg

// >>> hdl/efs_persist.sv
// persistence timer: fault once a condition holds for a count of ticks
`timescale 1ns/1ns
module efs_persist
    import efs_pkg::*;
#(
    parameter int CNT_W = 8
)
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic cond,
    input wire logic tick,
    input wire logic [CNT_W-1:0] limit,
    output logic fault
);
    import efs_pkg::*;

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic fault;
    } efs_persist_s;

    efs_persist_s r;
    efs_persist_s next_r;

    always_comb
    begin
        next_r = r;
        if (!cond)
        begin
            next_r.cnt = '0;
        end
        else if (tick && r.cnt != {CNT_W{1'b1}})
        begin
            next_r.cnt = r.cnt + 1'b1;
        end
        // zero limit trips at once; otherwise only unbroken persistence counts
        next_r.fault = cond && (next_r.cnt >= limit);
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign fault = r.fault;

endmodule : efs_persist

// >>> sim/efs_encoder_model.sv
// quadrature encoder model driving the two shaft phases
`timescale 1ns/1ns
module efs_encoder_model
(
    input wire logic clk_sys,
    input wire logic run,
    input wire logic rev,
    input wire logic [7:0] per,
    output logic enc_a,
    output logic enc_b
);
    logic [7:0] cnt = 8'h00;
    logic [1:0] ph = 2'h0;
    // gray order: a leads b unless rev; a shaft at rest keeps its last phase
    assign enc_a = ^ph;
    assign enc_b = ph[1];
    always @(posedge clk_sys)
    begin
        cnt <= (run && cnt < per - 8'h01) ? cnt + 8'h01 : 8'h00;
        if (run && cnt == per - 8'h01)
            ph <= rev ? ph - 2'h1 : ph + 2'h1;
    end
endmodule : efs_encoder_model

// >>> sim/efs_properties.sv
// port assertions for the encoder feedback supervisor
`timescale 1ns/1ns
module efs_properties
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic enc_div_pulse,
    input wire logic overspeed_fault,
    input wire logic speed_deviation_fault,
    input wire logic encoder_loss_fault,
    input wire logic stop_decel,
    input wire logic stop_coast,
    input wire logic irq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire any_f = overspeed_fault | speed_deviation_fault | encoder_loss_fault;
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    chk_wr_answer: assert property (wr_take |-> ##[2:3] s_axi_bvalid)
        else $error("write answer missing");
    chk_wr_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answering");
    chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
    chk_rd_answer: assert property (rd_take |-> ##[1:2] s_axi_rvalid)
        else $error("read answer missing");
    chk_rd_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answering");
    chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read answer dropped");
    chk_div_single: assert property (enc_div_pulse |=> !enc_div_pulse)
        else $error("divided pulse too long");
    chk_coast_cause: assert property (stop_coast |-> any_f && !stop_decel)
        else $error("coast without fault");
    chk_decel_cause: assert property (stop_decel |-> any_f)
        else $error("decel without fault");
    chk_irq_cause: assert property (irq |-> any_f)
        else $error("irq without fault");
    chk_os_sticky: assert property ($fell(overspeed_fault) |-> ##[0:2] s_axi_bvalid)
        else $error("fault cleared without write");
endmodule : efs_properties

bind efs_supervisor efs_properties chk_u (.*);

// >>> sim/encoder_feedback_supervisor_tb_top.sv
// self-checking bench for the encoder feedback supervisor
`timescale 1ns/1ns
module encoder_feedback_supervisor_tb_top;
    import efs_pkg::*;
    localparam int GC = 200;
    logic clk_sys = 1'h0, rst = 1'h1, run = 1'h0, rev = 1'h0;
    logic [5:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [15:0] ref_speed_rpm = '0, speed_rpm;
    logic [7:0] per = 8'h0a;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic shaft_encoder_a, shaft_encoder_b, dir_fwd, enc_div_pulse, irq, stop_decel, stop_coast;
    logic overspeed_fault, speed_deviation_fault, encoder_loss_fault;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    int n_errors = 0, n_checks = 0, cyc = 0, na = 0, nd = 0;
    wire [2:0] flt = {encoder_loss_fault, speed_deviation_fault, overspeed_fault};
    logic [31:0] rstv [8] = '{32'h0, 32'h0a78, 32'h050a, 32'h0a, 32'h0400, 32'h1, 32'h10001, 32'h0708};
    int pers [4] = '{5, 10, 25, 50};
    int divs [4] = '{1, 32, 132, 105};

    efs_supervisor #(.GATE_CYCLES(GC)) dut_u (.*);
    efs_encoder_model enc_u (.clk_sys(clk_sys), .run(run), .rev(rev), .per(per),
        .enc_a(shaft_encoder_a), .enc_b(shaft_encoder_b));

    always #10 clk_sys = ~clk_sys;
    always @(posedge shaft_encoder_a) na++;
    always @(negedge clk_sys) nd <= nd + int'(enc_div_pulse === 1'h1);
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc > 40000)
        begin
            n_errors++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic ticks(input int n);
        repeat (n * GC) @(posedge clk_sys);
    endtask : ticks

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic pa, pw, ta, tw, tb;
        pa = 1'h1;
        pw = 1'h1;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do
        begin
            @(negedge clk_sys);
            ta = pa && s_axi_awready;
            tw = pw && s_axi_wready;
            tb = s_axi_bvalid;
            rs = s_axi_bresp;
            @(posedge clk_sys);
            if (ta) s_axi_awvalid <= 1'h0;
            if (tw) s_axi_wvalid <= 1'h0;
            pa = pa && !ta;
            pw = pw && !tw;
        end
        while (!tb);
        s_axi_bready <= 1'h0;
    endtask : wr

    task automatic rdr(input logic [5:0] a);
        logic pa, ta, tr;
        pa = 1'h1;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do
        begin
            @(negedge clk_sys);
            ta = pa && s_axi_arready;
            tr = s_axi_rvalid;
            rd = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge clk_sys);
            if (ta) s_axi_arvalid <= 1'h0;
            pa = pa && !ta;
        end
        while (!tr);
        s_axi_rready <= 1'h0;
    endtask : rdr

    // fault latency window, every reaction code, then the masked interrupt
    task automatic fault_case(input int f, input int t);
        int t0;
        t0 = cyc;
        while (flt[f] !== 1'h1) @(negedge clk_sys);
        chk(32'(cyc - t0 > (t - 1) * GC && cyc - t0 <= t * GC + GC / 2), 1);
        for (int s = 0; s < 3; s++)
        begin
            wr(OFS_CTRL, (32'h2a & ~(32'h3 << 2 * f)) | 32'(s) << 2 * f);
            chk({stop_coast, stop_decel}, s == 0 ? 1 : s == 1 ? 2 : 0);
        end
        wr(OFS_MASK, 32'h1 << f);
        chk(irq, 1);
        wr(OFS_MASK, 32'h0);
        chk(irq, 0);
    endtask : fault_case

    initial
    begin
        int p, l, q, e, v;
        void'($urandom(32'hbd7e20e0));
        repeat (2) @(posedge clk_sys);
        rst <= 1'h0;
        foreach (rstv[i])
        begin
            rdr(6'(4 * i));
            chk(rd, rstv[i]);
        end
        rdr(6'h2c);
        chk(rs, AXI_SLVERR);
        chk(rd, 0);
        wr(6'h2c, 32'h1);
        chk(rs, AXI_SLVERR);
        wr(OFS_MAX_RPM, 32'hea60);
        run <= 1'h1;
        for (int i = 0; i < 4; i++)
        begin
            p = pers[$urandom_range(3)];
            l = $urandom_range(3, 1);
            q = $urandom_range(4, 1);
            per <= 8'(p);
            rev <= i[0];
            wr(OFS_PPR, 32'(q));
            wr(OFS_GEAR, 32'(l) << 16 | 32'h1);
            wr(OFS_CTRL, 32'h2a | 32'(i[1]) << 6);
            ticks(3);
            e = (GC / (4 * p)) * 600 * l / q;
            rdr(OFS_SPEED);
            chk(rd, {15'h0, !i[0] ^ i[1], 16'(e)});
            chk(speed_rpm, e);
            chk(dir_fwd, !i[0] ^ i[1]);
        end
        per <= 8'h32;
        ref_speed_rpm <= 16'h0258;
        wr(OFS_PPR, 32'h1);
        wr(OFS_GEAR, 32'h10001);
        wr(OFS_MAX_RPM, 32'h07d0);
        wr(OFS_OS_CFG, 32'h0364);
        wr(OFS_DEV_CFG, 32'h0232);
        ticks(2);
        wr(OFS_STATUS, 32'h7);
        per <= 8'h0a;
        ref_speed_rpm <= 16'h0bb8;
        while (speed_rpm <= 16'h07d0) @(negedge clk_sys);
        fault_case(0, 3);
        wr(OFS_STATUS, 32'h2);
        ref_speed_rpm <= 16'h0f9f;
        ticks(4);
        chk(speed_deviation_fault, 0);
        ref_speed_rpm <= 16'h07cf;
        fault_case(1, 2);
        wr(OFS_LOSS_CFG, 32'h3);
        run <= 1'h0;
        ticks(2);
        chk(encoder_loss_fault, 0);
        run <= 1'h1;
        ticks(1);
        run <= 1'h0;
        fault_case(2, 3);
        wr(OFS_STATUS, 32'h1);
        wr(OFS_MASK, 32'h4);
        run <= 1'h1;
        ticks(1);
        wr(OFS_STATUS, 32'h4);
        chk({irq, encoder_loss_fault, overspeed_fault}, 0);
        per <= 8'h05;
        for (int i = 0; i < 5; i++)
        begin
            v = i < 4 ? divs[i] : 100 * $urandom_range(1, 0) + $urandom_range(32, 2);
            wr(OFS_DIVSET, 32'(v));
            @(posedge clk_sys);
            na = 0;
            nd = 0;
            repeat (2560) @(posedge clk_sys);
            e = na * (1 + v / 100) / (v % 100);
            chk(32'(nd >= e - 1 && nd <= e + 1), 1);
        end
        complete_run();
    end
endmodule : encoder_feedback_supervisor_tb_top
